// File: hcb_defs.vh
// Constants for the hub configuration byte decoder
`ifndef HCB_DEFS_VH
`define HCB_DEFS_VH
`define HCB_HDR_FULL        8'hd2
`define HCB_HDR_DEFAULT     8'hd0
`define HCB_IDX_FILTER      4'h7
`define HCB_IDX_PORTS       4'h8
`define HCB_IDX_BUDGET      4'h9
`define HCB_IDX_CTRL_CUR    4'ha
`define HCB_IDX_PGOOD       4'hb
`define HCB_IDX_MODE        4'hc
`define HCB_LAST_IDX        4'hc
`define HCB_DEF_FILTER      8'h88
`define HCB_DEF_PORTS       8'hff
`define HCB_DEF_BUDGET      8'h32
`define HCB_DEF_CTRL_CUR    8'h64
`define HCB_DEF_PGOOD       8'h32
`define HCB_DEF_MODE        8'h00
`define HCB_BIT_ACCEPT0     7
`define HCB_BIT_FULLSPD     5
`define HCB_BIT_IND_OFF     4
`define HCB_BIT_GANG        2
`define HCB_BIT_SINGLE_TT   1
`define HCB_BIT_NO_EOP      0
`define HCB_DESC_HUB        8'h29
`define HCB_DESC_ZERO       8'h00
`define HCB_MS_NS           1000000
`define HCB_CLK_NS          4
`endif

// File: hcb_image_mem.v
// Small image store for the thirteen configuration bytes
`timescale 1ns/100ps
`default_nettype none
module hcb_image_mem #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock
  input  wire          clk_i,
  input  wire          ce_i,
  // Write side
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]    wdata_i,
  // Read side
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]    rdata_o
);
  reg [7:0] mem_reg [0:DEPTH-1];

  // Registered read; no reset on the array to keep it a plain RAM
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule
`default_nettype wire

// File: hcb_oc_filter.v
// Per-port overcurrent persistence filter, counted in milliseconds
`timescale 1ns/100ps
`default_nettype none
module hcb_oc_filter #(
  parameter MS_CYC = 250000
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       ce_i,
  // Filter control
  input  wire       tick_i,
  input  wire [3:0] limit_ms_i,
  input  wire       oc_sync_i,
  // Result
  output reg        oc_o
);
  reg [4:0] ms_reg;

  // Shared tick may land just after onset, so one extra tick is counted
  // to guarantee the full limit; any drop restarts
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ms_reg <= 5'h00;
      oc_o   <= 1'b0;
    end else if (ce_i) begin
      if (!oc_sync_i) begin
        ms_reg <= 5'h00;
        oc_o   <= 1'b0;
      end else if ((limit_ms_i == 4'h0) || (ms_reg > {1'b0, limit_ms_i})) begin
        oc_o <= 1'b1;
      end else if (tick_i) begin
        ms_reg <= ms_reg + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: hcb_decoder.v
// Hub configuration image decoder and setting outputs
`timescale 1ns/100ps
`default_nettype none
`include "hcb_defs.vh"
module hcb_decoder #(
  parameter NPORT  = 4,
  parameter MS_CYC = `HCB_MS_NS / `HCB_CLK_NS
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire             ce_i,
  // Image byte stream from the memory reader (link clock domain)
  input  wire             byte_clk_i,
  input  wire             byte_valid_i,
  input  wire [7:0]       byte_data_i,
  input  wire             image_end_i,
  // Overcurrent and port state pins
  input  wire [NPORT-1:0] oc_pin_i,
  input  wire [NPORT-1:0] port_enabled_i,
  // Hub descriptor request check
  input  wire             desc_req_i,
  input  wire [7:0]       desc_type_i,
  // Load status
  output reg              load_done_o,
  output reg              full_load_o,
  output reg              enum_ready_o,
  // Identifiers
  output reg  [15:0]      vendor_identifier_o,
  output reg  [15:0]      product_identifier_o,
  output reg  [15:0]      device_release_identifier_o,
  // Decoded settings
  output reg  [3:0]       enabled_port_oc_filter_ms_o,
  output reg  [3:0]       disabled_port_oc_filter_ms_o,
  output reg  [3:0]       usable_port_mask_o,
  output reg  [3:0]       detachable_port_mask_o,
  output reg  [2:0]       port_count_o,
  output reg  [7:0]       upstream_current_budget_o,
  output reg  [7:0]       controller_current_draw_o,
  output reg  [7:0]       power_good_delay_o,
  output reg  [15:0]      hub_characteristics_o,
  output reg              accept_zero_desc_type_o,
  output reg              force_full_speed_o,
  output reg              indicators_off_o,
  output reg              shared_power_switching_o,
  output reg              shared_translator_mode_o,
  output reg              suppress_frame_end_eop_o,
  // Request outcome and filtered faults
  output reg              desc_stall_o,
  output reg              desc_accept_o,
  output reg  [NPORT-1:0] oc_filtered_o
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_READ  = 2'd1;
  localparam ST_APPLY = 2'd2;
  localparam ST_DONE  = 2'd3;
  // Default bytes, split into nibbles at reset
  localparam [7:0] DEF_FILTER_B = `HCB_DEF_FILTER;
  localparam [7:0] DEF_PORTS_B  = `HCB_DEF_PORTS;

  // Two-stage synchronisers for link clock, data strobe and pins
  reg [1:0]       bclk_sync_reg;
  reg [1:0]       bval_sync_reg;
  reg [1:0]       bend_sync_reg;
  reg [7:0]       bdat_s1_reg;
  reg [7:0]       bdat_s2_reg;
  reg             bclk_prev_reg;
  reg [NPORT-1:0] oc_s1_reg;
  reg [NPORT-1:0] oc_s2_reg;
  reg [NPORT-1:0] en_s1_reg;
  reg [NPORT-1:0] en_s2_reg;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bclk_sync_reg <= 2'b00;
      bval_sync_reg <= 2'b00;
      bend_sync_reg <= 2'b00;
      bdat_s1_reg   <= 8'h00;
      bdat_s2_reg   <= 8'h00;
      bclk_prev_reg <= 1'b0;
      oc_s1_reg     <= {NPORT{1'b0}};
      oc_s2_reg     <= {NPORT{1'b0}};
      en_s1_reg     <= {NPORT{1'b0}};
      en_s2_reg     <= {NPORT{1'b0}};
    end else if (ce_i) begin
      bclk_sync_reg <= {bclk_sync_reg[0], byte_clk_i};
      bval_sync_reg <= {bval_sync_reg[0], byte_valid_i};
      bend_sync_reg <= {bend_sync_reg[0], image_end_i};
      bdat_s1_reg   <= byte_data_i;
      bdat_s2_reg   <= bdat_s1_reg;
      bclk_prev_reg <= bclk_sync_reg[1];
      oc_s1_reg     <= oc_pin_i;
      oc_s2_reg     <= oc_s1_reg;
      en_s1_reg     <= port_enabled_i;
      en_s2_reg     <= en_s1_reg;
    end
  end

  // Byte taken on the link clock rising edge; data is stable by then
  wire byte_take = bclk_sync_reg[1] & ~bclk_prev_reg & bval_sync_reg[1];

  // Loader state
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [3:0] wr_idx_reg;
  reg  [3:0] rd_idx_reg;
  reg        hdr_full_reg;
  reg        apply_vld_reg;
  reg  [7:0] id_lo_reg;
  wire [7:0] mem_rdata;
  wire       mem_we = (state_reg == ST_READ) & byte_take & (wr_idx_reg <= `HCB_LAST_IDX);

  hcb_image_mem #(
    .DEPTH (16),
    .AW    (4)
  ) u_mem (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (wr_idx_reg),
    .wdata_i (bdat_s2_reg),
    .raddr_i (rd_idx_reg),
    .rdata_o (mem_rdata)
  );

  // Next state of the load sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = ST_READ;
      ST_READ: begin
        if (bend_sync_reg[1]) begin
          state_next = ST_APPLY;
        end
      end
      ST_APPLY: begin
        if (!hdr_full_reg || (rd_idx_reg > `HCB_LAST_IDX)) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE:  state_next = ST_DONE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // Byte capture, header decode and settings apply
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg                    <= ST_IDLE;
      wr_idx_reg                   <= 4'h0;
      rd_idx_reg                   <= `HCB_IDX_FILTER;
      hdr_full_reg                 <= 1'b0;
      apply_vld_reg                <= 1'b0;
      id_lo_reg                    <= 8'h00;
      load_done_o                  <= 1'b0;
      full_load_o                  <= 1'b0;
      enum_ready_o                 <= 1'b0;
      vendor_identifier_o          <= 16'h0000;
      product_identifier_o         <= 16'h0000;
      device_release_identifier_o  <= 16'h0000;
      enabled_port_oc_filter_ms_o  <= DEF_FILTER_B[7:4];
      disabled_port_oc_filter_ms_o <= DEF_FILTER_B[3:0];
      usable_port_mask_o           <= DEF_PORTS_B[7:4];
      detachable_port_mask_o       <= DEF_PORTS_B[3:0];
      upstream_current_budget_o    <= `HCB_DEF_BUDGET;
      controller_current_draw_o    <= `HCB_DEF_CTRL_CUR;
      power_good_delay_o           <= `HCB_DEF_PGOOD;
      accept_zero_desc_type_o      <= 1'b0;
      force_full_speed_o           <= 1'b0;
      indicators_off_o             <= 1'b0;
      shared_power_switching_o     <= 1'b0;
      shared_translator_mode_o     <= 1'b0;
      suppress_frame_end_eop_o     <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      // Raw bytes 0-6 decoded on the fly; 7-12 parked in the store
      if (state_reg == ST_READ && byte_take) begin
        if (wr_idx_reg != 4'hf) begin
          wr_idx_reg <= wr_idx_reg + 4'h1;
        end
        case (wr_idx_reg)
          4'h0: hdr_full_reg <= (bdat_s2_reg == `HCB_HDR_FULL);
          4'h1: id_lo_reg <= bdat_s2_reg;
          4'h2: vendor_identifier_o <= {bdat_s2_reg, id_lo_reg};
          4'h3: id_lo_reg <= bdat_s2_reg;
          4'h4: product_identifier_o <= {bdat_s2_reg, id_lo_reg};
          4'h5: id_lo_reg <= bdat_s2_reg;
          4'h6: device_release_identifier_o <= {bdat_s2_reg, id_lo_reg};
          default: id_lo_reg <= id_lo_reg;
        endcase
      end
      // Store read has one cycle of latency, hence the valid flag
      if (state_reg == ST_APPLY && hdr_full_reg) begin
        rd_idx_reg    <= rd_idx_reg + 4'h1;
        apply_vld_reg <= 1'b1;
      end else begin
        apply_vld_reg <= 1'b0;
      end
      if (apply_vld_reg) begin
        case (rd_idx_reg - 4'h1)
          `HCB_IDX_FILTER: begin
            enabled_port_oc_filter_ms_o  <= mem_rdata[7:4];
            disabled_port_oc_filter_ms_o <= mem_rdata[3:0];
          end
          `HCB_IDX_PORTS: begin
            usable_port_mask_o     <= mem_rdata[7:4];
            detachable_port_mask_o <= mem_rdata[3:0];
          end
          `HCB_IDX_BUDGET:   upstream_current_budget_o <= mem_rdata;
          `HCB_IDX_CTRL_CUR: controller_current_draw_o <= mem_rdata;
          `HCB_IDX_PGOOD:    power_good_delay_o        <= mem_rdata;
          `HCB_IDX_MODE: begin
            // Bits 6 and 3 deliberately unused
            accept_zero_desc_type_o  <= mem_rdata[`HCB_BIT_ACCEPT0];
            force_full_speed_o       <= mem_rdata[`HCB_BIT_FULLSPD];
            indicators_off_o         <= mem_rdata[`HCB_BIT_IND_OFF];
            shared_power_switching_o <= mem_rdata[`HCB_BIT_GANG];
            shared_translator_mode_o <= mem_rdata[`HCB_BIT_SINGLE_TT];
            suppress_frame_end_eop_o <= mem_rdata[`HCB_BIT_NO_EOP];
          end
          default: apply_vld_reg <= 1'b0;
        endcase
      end
      // Default load keeps reset defaults for the bytes 7-12 settings; identifiers still come from bytes 1-6
      if (state_reg == ST_APPLY && state_next == ST_DONE) begin
        load_done_o  <= 1'b1;
        full_load_o  <= hdr_full_reg;
      end
      enum_ready_o <= load_done_o;
    end
  end

  // Port count from the usable mask
  function [2:0] hcb_popcount;
    input [3:0] m;
    begin
      hcb_popcount = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
    end
  endfunction

  // Descriptor fields: b4:b3 overcurrent, b1:b0 switching, b7 indicators
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_count_o          <= 3'h4;
      hub_characteristics_o <= 16'h0089;
    end else if (ce_i) begin
      port_count_o <= hcb_popcount(usable_port_mask_o);
      hub_characteristics_o <= {8'h00, ~indicators_off_o, 2'b00,
        shared_power_switching_o ? 2'b00 : 2'b01, 1'b0,
        shared_power_switching_o ? 2'b00 : 2'b01};
    end
  end

  // Hub descriptor type check; answered only once loading is done
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      desc_stall_o  <= 1'b0;
      desc_accept_o <= 1'b0;
    end else if (ce_i) begin
      desc_stall_o  <= 1'b0;
      desc_accept_o <= 1'b0;
      if (desc_req_i && enum_ready_o) begin
        if (desc_type_i == `HCB_DESC_HUB ||
            (desc_type_i == `HCB_DESC_ZERO && accept_zero_desc_type_o)) begin
          desc_accept_o <= 1'b1;
        end else begin
          desc_stall_o <= 1'b1;
        end
      end
    end
  end

  // Shared millisecond tick for all port filters
  reg [31:0] ms_cnt_reg;
  reg        ms_tick_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ms_cnt_reg  <= 32'h0;
      ms_tick_reg <= 1'b0;
    end else if (ce_i) begin
      ms_tick_reg <= (ms_cnt_reg == MS_CYC - 1);
      ms_cnt_reg  <= (ms_cnt_reg == MS_CYC - 1) ? 32'h0 : ms_cnt_reg + 32'h1;
    end
  end

  // One filter per port, limit picked by port enable state
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_oc
      wire oc_q;
      hcb_oc_filter #(
        .MS_CYC (MS_CYC)
      ) u_filt (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .tick_i     (ms_tick_reg),
        .limit_ms_i (en_s2_reg[p] ? enabled_port_oc_filter_ms_o :
                     disabled_port_oc_filter_ms_o),
        .oc_sync_i  (oc_s2_reg[p]),
        .oc_o       (oc_q)
      );
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          oc_filtered_o[p] <= 1'b0;
        end else if (ce_i) begin
          oc_filtered_o[p] <= oc_q;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: hcb_eeprom_model.sv
// Serial memory model streaming the hub configuration image
`timescale 1ns/100ps
`default_nettype none
module hcb_eeprom_model (
  // Load status from the decoder
  input  wire logic  done_i,
  // Image byte stream
  output logic       byte_clk_o,
  output logic       byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic       image_end_o
);
  // Link clock stands low outside frames
  initial begin
    byte_clk_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_data_o = 8'h00;
    image_end_o = 1'b0;
  end

  // Sequential read from address zero, data steady either side of the edge
  task automatic send(input logic [7:0] img [14], input int n);
    for (int i = 0; i < n; i++) begin
      byte_data_o = img[i];
      byte_valid_o = 1'b1;
      #16 byte_clk_o = 1'b1;
      #16 byte_clk_o = 1'b0;
    end
    // Released data goes to the inverse so a stale byte never looks valid
    byte_valid_o = 1'b0;
    byte_data_o = ~byte_data_o;
    image_end_o = 1'b1;
    wait (done_i === 1'b1);
    #8 image_end_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: hcb_decoder_asserts.sv
// Concurrent checks on the decoder's request and descriptor outputs
`timescale 1ns/100ps
`default_nettype none
module hcb_decoder_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  // Request side
  input wire logic        desc_req_i,
  input wire logic [7:0]  desc_type_i,
  input wire logic        desc_stall_o,
  input wire logic        desc_accept_o,
  // Load status and settings
  input wire logic        load_done_o,
  input wire logic        enum_ready_o,
  input wire logic        accept_zero_desc_type_o,
  input wire logic        indicators_off_o,
  input wire logic        shared_power_switching_o,
  input wire logic [3:0]  usable_port_mask_o,
  input wire logic [2:0]  port_count_o,
  input wire logic [15:0] hub_characteristics_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // A request seen with the clock enable high once ready is answered on the next cycle according to its type
  stall_zero_a: assert property (ce_i && desc_req_i && enum_ready_o && desc_type_i == 8'h00
    && !accept_zero_desc_type_o |=> desc_stall_o && !desc_accept_o)
    else $error("type zero not stalled");
  zero_accept_a: assert property (ce_i && desc_req_i && enum_ready_o && desc_type_i == 8'h00
    && accept_zero_desc_type_o |=> desc_accept_o && !desc_stall_o)
    else $error("type zero not accepted");
  hub_type_a: assert property (ce_i && desc_req_i && enum_ready_o && desc_type_i == 8'h29
    |=> desc_accept_o && !desc_stall_o)
    else $error("hub type not accepted");
  early_req_a: assert property (desc_req_i && !enum_ready_o
    |=> !desc_stall_o && !desc_accept_o)
    else $error("request answered before ready");
  ready_gate_a: assert property (enum_ready_o |-> load_done_o)
    else $error("ready without load done");
  ready_follow_a: assert property ($rose(load_done_o) |=> enum_ready_o)
    else $error("ready late after load done");
  // Descriptor fields settle in the same cycle that ready rises
  port_count_a: assert property (enum_ready_o && $past(enum_ready_o, 3)
    |-> port_count_o == $countones(usable_port_mask_o))
    else $error("port count not mask population");
  indicator_bit_a: assert property (enum_ready_o && $past(enum_ready_o, 3)
    |-> hub_characteristics_o[7] == !indicators_off_o)
    else $error("indicator bit wrong");
  gang_bits_a: assert property (enum_ready_o && $past(enum_ready_o, 3)
    |-> {hub_characteristics_o[4:3], hub_characteristics_o[1:0]}
    == (shared_power_switching_o ? 4'b0000 : 4'b0101))
    else $error("switching bits wrong");
endmodule

bind hcb_decoder hcb_decoder_chk u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .desc_req_i(desc_req_i), .desc_type_i(desc_type_i),
  .desc_stall_o(desc_stall_o), .desc_accept_o(desc_accept_o), .load_done_o(load_done_o),
  .enum_ready_o(enum_ready_o), .accept_zero_desc_type_o(accept_zero_desc_type_o),
  .indicators_off_o(indicators_off_o), .shared_power_switching_o(shared_power_switching_o),
  .usable_port_mask_o(usable_port_mask_o), .port_count_o(port_count_o),
  .hub_characteristics_o(hub_characteristics_o)
);
`default_nettype wire

// File: hcb_decoder_tb.sv
// Self-checking bench for the hub configuration byte decoder
`timescale 1ns/100ps
`default_nettype none
module hcb_decoder_tb;
  logic        clk_i, nrst_i, ce_i, req, bclk, bval, bend;
  logic        stall, acc, done, full, rdy, azd, ffs, ioff, gang, stt, noeop;
  logic [7:0]  dtype, bdat, bud, ccur, pgd;
  logic [3:0]  oc, pen, ocf, efl, dfl, use_m, det;
  logic [15:0] vendor_identifier, product_identifier, device_release_identifier, hc;
  logic [2:0]  pc;
  logic [7:0]  im [14];
  int          err_total, n_tests;

  // Short filter tick so millisecond filters fit the run
  hcb_decoder #(.NPORT(4), .MS_CYC(10)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .byte_clk_i(bclk),
    .byte_valid_i(bval), .byte_data_i(bdat), .image_end_i(bend),
    .oc_pin_i(oc), .port_enabled_i(pen), .desc_req_i(req), .desc_type_i(dtype),
    .load_done_o(done), .full_load_o(full), .enum_ready_o(rdy),
    .vendor_identifier_o(vendor_identifier), .product_identifier_o(product_identifier),
    .device_release_identifier_o(device_release_identifier), .enabled_port_oc_filter_ms_o(efl),
    .disabled_port_oc_filter_ms_o(dfl), .usable_port_mask_o(use_m),
    .detachable_port_mask_o(det), .port_count_o(pc), .upstream_current_budget_o(bud),
    .controller_current_draw_o(ccur), .power_good_delay_o(pgd),
    .hub_characteristics_o(hc), .accept_zero_desc_type_o(azd),
    .force_full_speed_o(ffs), .indicators_off_o(ioff),
    .shared_power_switching_o(gang), .shared_translator_mode_o(stt),
    .suppress_frame_end_eop_o(noeop), .desc_stall_o(stall), .desc_accept_o(acc),
    .oc_filtered_o(ocf)
  );

  hcb_eeprom_model u_mem (
    .done_i(done), .byte_clk_o(bclk), .byte_valid_o(bval),
    .byte_data_o(bdat), .image_end_o(bend)
  );

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic results();
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask

  // One descriptor request; collects {stall, accept} over the answer window
  task automatic desc(input logic [7:0] t, input logic [1:0] exp);
    logic [1:0] seen;
    seen = 2'b00;
    @(posedge clk_i);
    req <= 1'b1;
    dtype <= t;
    repeat (3) begin
      @(posedge clk_i);
      req <= 1'b0;
      #1 seen = seen | {stall, acc};
    end
    chk(seen, exp);
  endtask

  // Expected settings come straight from the image bytes
  task automatic cfg(input logic fl);
    logic [7:0] m;
    m = im[12];
    chk(full, fl);
    chk({vendor_identifier, product_identifier, device_release_identifier}, {im[2], im[1], im[4], im[3], im[6], im[5]});
    chk({efl, dfl}, im[7]);
    chk({use_m, det}, im[8]);
    chk(pc, $countones(im[8][7:4]));
    chk({bud, ccur, pgd}, {im[9], im[10], im[11]});
    chk({azd, ffs, ioff, gang, stt, noeop}, {m[7], m[5:4], m[2:0]});
    chk(hc, {8'h00, ~m[4], 3'b000, ~m[2], 2'b00, ~m[2]});
  endtask

  task automatic load(input int n, input logic fl);
    u_mem.send(im, n);
    // Ready and descriptor fields both one cycle after done
    repeat (4) @(posedge clk_i);
    #1 chk(rdy, 1'b1);
    cfg(fl);
  endtask

  task automatic ocw(input int c, input logic [3:0] e);
    repeat (c) @(posedge clk_i);
    #1 chk(ocf, e);
  endtask

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    req = 1'b0;
    dtype = 8'h00;
    oc = 4'h0;
    pen = 4'h1;
    err_total = 0;
    n_tests = 0;
    rst();
    desc(8'h29, 2'b00);
    im = '{8'hd2, 8'h34, 8'h12, 8'h78, 8'h56, 8'hbc, 8'h9a,
           8'h52, 8'h96, 8'h7a, 8'h45, 8'h19, 8'hf7, 8'hc3};
    load(14, 1'b1);
    desc(8'h00, 2'b01);
    desc(8'h29, 2'b01);
    // Port 0 enabled (5 ms), port 1 disabled (2 ms)
    @(posedge clk_i);
    oc <= 4'h3;
    // Neither filter may accept before its full count of milliseconds
    ocw(20, 4'h0);
    ocw(15, 4'h2);
    ocw(15, 4'h2);
    ocw(15, 4'h3);
    oc <= 4'h0;
    rst();
    im[8] = 8'h7c;
    im[12] = 8'h44;
    load(14, 1'b1);
    desc(8'h00, 2'b10);
    desc(8'h29, 2'b01);
    // Clock enable low freezes the block, so no answer
    @(posedge clk_i);
    ce_i <= 1'b0;
    desc(8'h29, 2'b00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rst();
    im = '{8'hd0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
           8'h88, 8'hff, 8'h32, 8'h64, 8'h32, 8'h00, 8'h00};
    load(7, 1'b0);
    results();
  end

  // Watchdog well beyond the expected few microseconds
  initial begin
    #20000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
